// ==== core/mss_defines.svh ====
// Constants for the multiphase soft-start sequencer
`ifndef MSS_DEFINES_SVH
`define MSS_DEFINES_SVH
`define MSS_CLK_MHZ        200
`define MSS_CMD_DELAY      8'hD4
`define MSS_CMD_SLEW       8'hD5
`define MSS_CMD_LL_CAL     8'hDE
`define MSS_CMD_LL_SET     8'hDF
`define MSS_CMD_ILIM       8'hE2
`define MSS_CMD_IMON       8'h8C
`define MSS_DELAY_RST      3'h3
`define MSS_SLEW_RST       3'h2
`define MSS_SCALE5_RST     5'h10
`define MSS_DELAY_STEP_US  500
`define MSS_STEP_UV        6250
`define MSS_SLEW_BASE_UV   100
`define MSS_SLEW_STEP_UV   200
`define MSS_BOOT_CODE      8'hB0
`define MSS_DETECT_CYC     3'h6
`define MSS_LATCH_MULT     4
`define MSS_NPH            6
`define MSS_PH_BITS        3
`endif

// ==== core/mss_pkg.sv ====
// Types for the multiphase soft-start sequencer
package mss_pkg;
    typedef enum logic [2:0] {
        MSS_IDLE   = 3'b000,
        MSS_DELAY  = 3'b001,
        MSS_DETECT = 3'b011,
        MSS_RAMP1  = 3'b010,
        MSS_HOLD   = 3'b110,
        MSS_RAMP2  = 3'b111,
        MSS_RUN    = 3'b101
    } mss_state_e;
endpackage : mss_pkg

// ==== core/mss_sequencer.sv ====
// Startup sequencer, phase detection and settings for a multiphase buck
// Function
// - Ramp reference at programmable slew, default 0.5V/ms
// - First ramp after delay and detection complete
// - Step reference up 6.25mV to boot level
// - Boot level reached starts boot hold
// - After hold ramp to target, up or down
// - Slew code bits 2:0, default 010
// - Six phases unless detection finds unused
// - Weak pull-down on phases 2-6 before start
// - Phase pin above threshold marks unused
// - Phase 1 low during six detection cycles
// - Used phases drive normally after detection
// - Unused phases go high impedance after detection
// - Phases take turns from one shared slot counter, never overlap
// - Phase rate is master clock over count
// - Trip when limit current exceeds reference
// - Limit scale bits 4:0, default 10000
// - Load-line scale from two combined commands
// - Load current readable over serial port
// - Delay starts after enable and lockout release
// - Delay code bits 2:0, default 011
// - Latchoff timer is four delay intervals
`timescale 1ns/100ps
`include "mss_defines.svh"
module mss_sequencer import mss_pkg::*; #(
    parameter int DELAY_STEP_CYC =
        `MSS_DELAY_STEP_US * `MSS_CLK_MHZ,
    parameter int MCLK_DIV = 40
) (
    // Clock and reset
    input  wire logic                    clk_in,
    input  wire logic                    reset_in,
    // Startup conditions
    input  wire logic                    enable_in,
    input  wire logic                    undervoltage_lockout_released_in,
    input  wire logic [7:0]              target_voltage_code_in,
    // Serial command port
    input  wire logic                    cmd_wr_in,
    input  wire logic                    cmd_rd_in,
    input  wire logic [7:0]              cmd_code_in,
    input  wire logic [7:0]              cmd_wdata_in,
    output logic      [7:0]              cmd_rdata_out,
    // Analog sense results
    input  wire logic                    limit_over_ref_in,
    input  wire logic [7:0]              load_current_in,
    // Phase pins: comparator above threshold, drive, enable, sink
    input  wire logic [`MSS_NPH-1:0]     phase_high_in,
    output logic      [`MSS_NPH-1:0]     phase_out,
    output logic      [`MSS_NPH-1:0]     phase_oe_out,
    output logic      [`MSS_NPH-1:0]     phase_sink_out,
    // Status
    output logic      [7:0]              ref_code_out,
    output logic      [`MSS_PH_BITS-1:0] phase_count_out,
    output logic      [5:0]              ll_scale_out,
    output logic      [4:0]              ilim_scale_out,
    output logic                         ilim_trip_out,
    output logic                         latchoff_out,
    output logic                         startup_done_out
);
    mss_state_e                 state_r;
    logic [2:0]                 delay_code_r;
    logic [2:0]                 slew_code_r;
    logic [4:0]                 ll_cal_r;
    logic [4:0]                 ll_set_r;
    logic [4:0]                 ilim_r;
    logic [31:0]                tmr_r;
    logic [31:0]                step_r;
    logic [31:0]                delay_cyc;
    logic [31:0]                step_cyc;
    logic [31:0]                slew_rate;
    logic [2:0]                 det_r;
    logic [`MSS_NPH-1:0]        unused_r;
    logic [7:0]                 mclk_r;
    logic [`MSS_PH_BITS-1:0]    slot_r;
    logic [31:0]                lat_r;
    logic                       run;
    logic                       seq_on;

    assign seq_on = enable_in && undervoltage_lockout_released_in;

    // Delay interval from its code, 0.5 ms per code step
    assign delay_cyc = 32'(({29'h0, delay_code_r} + 32'h1) * DELAY_STEP_CYC);

    // Slew in uV/us is base plus step per code; one step lasts 6.25mV/slew
    // Rounded up so the ramp never runs faster than the selected rate
    assign slew_rate = 32'(`MSS_SLEW_BASE_UV) +
                       32'(`MSS_SLEW_STEP_UV) * {29'h0, slew_code_r};
    assign step_cyc = (32'(`MSS_STEP_UV) * 32'(`MSS_CLK_MHZ) +
                       slew_rate - 32'h1) / slew_rate;

    // Command register writes
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            delay_code_r <= `MSS_DELAY_RST;
            slew_code_r  <= `MSS_SLEW_RST;
            ilim_r       <= `MSS_SCALE5_RST;
            ll_cal_r     <= `MSS_SCALE5_RST;
            ll_set_r     <= `MSS_SCALE5_RST;
        end else if (cmd_wr_in) begin
            unique case (cmd_code_in)
                `MSS_CMD_DELAY:  delay_code_r <= cmd_wdata_in[2:0];
                `MSS_CMD_SLEW:   slew_code_r  <= cmd_wdata_in[2:0];
                `MSS_CMD_ILIM:   ilim_r       <= cmd_wdata_in[4:0];
                `MSS_CMD_LL_CAL: ll_cal_r     <= cmd_wdata_in[4:0];
                `MSS_CMD_LL_SET: ll_set_r     <= cmd_wdata_in[4:0];
                default: ;
            endcase
        end
    end

    // Command readback; unknown codes read zero
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            cmd_rdata_out <= 8'h00;
        end else if (cmd_rd_in) begin
            unique case (cmd_code_in)
                `MSS_CMD_DELAY:  cmd_rdata_out <= {5'h00, delay_code_r};
                `MSS_CMD_SLEW:   cmd_rdata_out <= {5'h00, slew_code_r};
                `MSS_CMD_ILIM:   cmd_rdata_out <= {3'h0, ilim_r};
                `MSS_CMD_LL_CAL: cmd_rdata_out <= {3'h0, ll_cal_r};
                `MSS_CMD_LL_SET: cmd_rdata_out <= {3'h0, ll_set_r};
                `MSS_CMD_IMON:   cmd_rdata_out <= load_current_in;
                default:         cmd_rdata_out <= 8'h00;
            endcase
        end
    end

    // Startup state machine; dropping enable restarts it
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            state_r <= MSS_IDLE;
            tmr_r   <= 32'h0;
            step_r  <= 32'h0;
            det_r   <= 3'h0;
            ref_code_out <= 8'h00;
        end else if (!seq_on) begin
            state_r <= MSS_IDLE;
            tmr_r   <= 32'h0;
            step_r  <= 32'h0;
            det_r   <= 3'h0;
            ref_code_out <= 8'h00;
        end else begin
            unique case (state_r)
                MSS_IDLE: begin
                    state_r <= MSS_DELAY;
                    tmr_r   <= 32'h0;
                end
                MSS_DELAY: begin
                    if (tmr_r + 32'h1 >= delay_cyc) begin
                        state_r <= MSS_DETECT;
                        det_r   <= 3'h0;
                    end else begin
                        tmr_r <= tmr_r + 32'h1;
                    end
                end
                MSS_DETECT: begin
                    if (mclk_r == 8'h00) begin
                        if (det_r + 3'h1 == `MSS_DETECT_CYC) begin
                            state_r <= MSS_RAMP1;
                            step_r  <= 32'h0;
                        end
                        det_r <= det_r + 3'h1;
                    end
                end
                MSS_RAMP1: begin
                    if (ref_code_out >= `MSS_BOOT_CODE) begin
                        state_r <= MSS_HOLD;
                        tmr_r   <= 32'h0;
                    end else if (step_r + 32'h1 >= step_cyc) begin
                        step_r <= 32'h0;
                        ref_code_out <= ref_code_out + 8'h01;
                    end else begin
                        step_r <= step_r + 32'h1;
                    end
                end
                MSS_HOLD: begin
                    if (tmr_r + 32'h1 >= delay_cyc) begin
                        state_r <= MSS_RAMP2;
                        step_r  <= 32'h0;
                    end else begin
                        tmr_r <= tmr_r + 32'h1;
                    end
                end
                MSS_RAMP2: begin
                    if (ref_code_out == target_voltage_code_in) begin
                        state_r <= MSS_RUN;
                    end else if (step_r + 32'h1 >= step_cyc) begin
                        step_r <= 32'h0;
                        if (ref_code_out < target_voltage_code_in)
                            ref_code_out <= ref_code_out + 8'h01;
                        else
                            ref_code_out <= ref_code_out - 8'h01;
                    end else begin
                        step_r <= step_r + 32'h1;
                    end
                end
                MSS_RUN: begin
                    ref_code_out <= target_voltage_code_in;
                end
                default: state_r <= MSS_IDLE;
            endcase
        end
    end

    // Phases switch only from the first ramp on; the master clock runs free
    assign run = (state_r == MSS_RAMP1) || (state_r == MSS_HOLD) ||
                 (state_r == MSS_RAMP2) || (state_r == MSS_RUN);

    // Master clock divider and phase slot; rate per phase is mclk/count
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            mclk_r <= 8'h00;
            slot_r <= '0;
        end else if (mclk_r == 8'(MCLK_DIV - 1)) begin
            mclk_r <= 8'h00;
            if (slot_r + 3'h1 >= phase_count_out)
                slot_r <= '0;
            else
                slot_r <= slot_r + 3'h1;
        end else begin
            mclk_r <= mclk_r + 8'h01;
        end
    end

    // Detection: sample tied-high pins, latch count at end
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            unused_r        <= '0;
            phase_count_out <= 3'(`MSS_NPH);
        end else if (state_r == MSS_DELAY) begin
            unused_r        <= '0;
            phase_count_out <= 3'(`MSS_NPH);
        end else if (state_r == MSS_DETECT && mclk_r == 8'h00 &&
                     det_r + 3'h1 == `MSS_DETECT_CYC) begin
            unused_r        <= phase_high_in & 6'h3E;
            phase_count_out <= phase_high_in[1] ? 3'h1 :
                               phase_high_in[2] ? 3'h2 :
                               phase_high_in[3] ? 3'h3 :
                               phase_high_in[4] ? 3'h4 :
                               phase_high_in[5] ? 3'h5 : 3'h6;
        end
    end

    // Per-phase pin control; each phase has its own slot and enable
    genvar g;
    generate
        for (g = 0; g < `MSS_NPH; g++) begin : g_phase
            always_ff @(posedge clk_in or posedge reset_in) begin
                if (reset_in) begin
                    phase_out[g]      <= 1'b0;
                    phase_oe_out[g]   <= 1'b0;
                    phase_sink_out[g] <= 1'b0;
                end else if (g == 0) begin
                    phase_oe_out[g]   <= seq_on;
                    phase_sink_out[g] <= 1'b0;
                    phase_out[g] <= run && slot_r == 3'(g);
                end else begin
                    // Sink follows enable, not lockout release, until run, so it is on before release
                    phase_sink_out[g] <= enable_in && !run;
                    phase_oe_out[g]   <= run && !unused_r[g];
                    phase_out[g] <= run && !unused_r[g] &&
                                    slot_r == 3'(g);
                end
            end
        end
    endgenerate

    // Limit trip and latchoff timer of four delay intervals
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            ilim_trip_out <= 1'b0;
            latchoff_out  <= 1'b0;
            lat_r         <= 32'h0;
        end else if (!seq_on) begin
            ilim_trip_out <= 1'b0;
            latchoff_out  <= 1'b0; // Enable low clears latchoff
            lat_r         <= 32'h0;
        end else begin
            ilim_trip_out <= limit_over_ref_in;
            if (!limit_over_ref_in || state_r != MSS_RUN)
                lat_r <= 32'h0;
            else if (lat_r >= 32'(`MSS_LATCH_MULT) * delay_cyc)
                latchoff_out <= 1'b1;
            else
                lat_r <= lat_r + 32'h1;
        end
    end

    // Scales presented to the analog side
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            ilim_scale_out <= `MSS_SCALE5_RST;
            ll_scale_out   <= {1'b0, `MSS_SCALE5_RST} +
                              {1'b0, `MSS_SCALE5_RST};
        end else begin
            ilim_scale_out <= ilim_r;
            ll_scale_out   <= {1'b0, ll_cal_r} + {1'b0, ll_set_r};
        end
    end

    // Done flag once the target is reached
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) startup_done_out <= 1'b0;
        else          startup_done_out <= (state_r == MSS_RUN);
    end

    // Checks
    sequence s_boot_reached;
        state_r == MSS_RAMP1 && ref_code_out >= `MSS_BOOT_CODE;
    endsequence
    a_boot_hold_start: assert property (@(posedge clk_in) disable iff
        (reset_in) (s_boot_reached and seq_on) |=> state_r == MSS_HOLD)
        else $error("boot hold not entered");
    a_sink_enabled: assert property (@(posedge clk_in)
        disable iff (reset_in) enable_in && !run |=> phase_sink_out[1])
        else $error("pull-down missing while enabled");
    a_ramp_after_det: assert property (@(posedge clk_in) disable iff
        (reset_in) $rose(state_r == MSS_RAMP1) |-> $past(state_r) ==
        MSS_DETECT)
        else $error("ramp without detection");
    a_phase1_low_det: assert property (@(posedge clk_in) disable iff
        (reset_in) state_r == MSS_DETECT |=> !phase_out[0] || run)
        else $error("phase 1 active in detection");
    a_step_one_lsb: assert property (@(posedge clk_in) disable iff
        (reset_in) state_r == MSS_RAMP1 && seq_on && $changed(ref_code_out)
        |-> ref_code_out == $past(ref_code_out) + 8'h01)
        else $error("ramp step not one lsb");
    a_unused_hiz: assert property (@(posedge clk_in) disable iff
        (reset_in) run && unused_r[5] |=> !phase_oe_out[5])
        else $error("unused phase driven");
    a_sink_prestart: assert property (@(posedge clk_in) disable iff
        (reset_in) seq_on && state_r == MSS_DELAY |=> phase_sink_out[1])
        else $error("pull-down missing");
    a_trip_follows: assert property (@(posedge clk_in) disable iff
        (reset_in) seq_on && limit_over_ref_in |=> ilim_trip_out)
        else $error("limit trip missed");
    a_target_move: assert property (@(posedge clk_in) disable iff
        (reset_in) state_r == MSS_RAMP2 && seq_on &&
        ref_code_out < target_voltage_code_in &&
        $stable(target_voltage_code_in)
        |=> ref_code_out >= $past(ref_code_out))
        else $error("final ramp wrong direction");
endmodule : mss_sequencer

// ==== test/mss_gate_drv_model.sv ====
// Board straps and gate-driver inputs as seen from the phase pins
`timescale 1ns/100ps
module mss_gate_drv_model (
    // Clock
    input  wire logic       clk_in,
    // Phase pins from the sequencer
    input  wire logic [5:0] phase_in,
    input  wire logic [5:0] phase_oe_in,
    input  wire logic [5:0] phase_sink_in,
    // Straps, a set bit ties that pin to the supply
    input  wire logic [5:0] tie_mask_in,
    // Comparator view, pin level and contention count
    output logic      [5:0] phase_high_out,
    output logic      [5:0] pin_level_out,
    output int              clash_count_out
);
    logic [5:0] float_r = 6'h15;

    // An unheld pin wanders, so a stale level can never pass for a real one
    always_ff @(posedge clk_in) begin
        float_r <= ~float_r;
    end

    // Strap wins, then the driver, then the weak sink
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            if (tie_mask_in[i]) begin
                pin_level_out[i] = 1'b1;
            end else if (phase_oe_in[i]) begin
                pin_level_out[i] = phase_in[i];
            end else if (phase_sink_in[i]) begin
                pin_level_out[i] = 1'b0;
            end else begin
                pin_level_out[i] = float_r[i];
            end
        end
        phase_high_out = pin_level_out;
    end

    // Driving a strapped pin fights the supply
    initial clash_count_out = 0;
    always @(posedge clk_in) begin
        if ((tie_mask_in & phase_oe_in) != 6'h00) begin
            clash_count_out <= clash_count_out + 1;
        end
    end
endmodule : mss_gate_drv_model

// ==== test/tb.sv ====
// Self-checking bench for the multiphase soft-start sequencer
`timescale 1ns/100ps
`include "mss_defines.svh"
module tb;
    localparam int DSTEP = 20;
    localparam int MDIV  = 40;
    logic       clk_in            = 1'b0;
    logic       reset_in          = 1'b1;
    logic       enable_in         = 1'b0;
    logic       undervoltage_lockout_released_in  = 1'b0;
    logic [7:0] target_code       = 8'hB4;
    logic       cmd_wr_in         = 1'b0;
    logic       cmd_rd_in         = 1'b0;
    logic [7:0] cmd_code_in       = 8'h00;
    logic [7:0] cmd_wdata_in      = 8'h00;
    logic       limit_over_ref_in = 1'b0;
    logic [7:0] load_current_in   = 8'h5A;
    logic [5:0] tie_mask          = 6'h00;
    logic [7:0] cmd_rdata_out, ref_code_out;
    logic [5:0] phase_high, phase_out, phase_oe_out, phase_sink_out;
    logic [2:0] phase_count_out;
    logic [5:0] ll_scale_out;
    logic [4:0] ilim_scale_out;
    logic       ilim_trip_out, latchoff_out, startup_done_out;
    int         clash_count;
    int         err_total  = 0;
    int         num_checks = 0;
    logic [7:0] lim_codes [6] = '{8'h00, 8'h01, 8'h10, 8'h11, 8'h1E, 8'h1F};

    // 200 MHz clock
    always #2.5 clk_in = ~clk_in;

    mss_sequencer #(.DELAY_STEP_CYC(DSTEP), .MCLK_DIV(MDIV)) dut (
        .clk_in(clk_in), .reset_in(reset_in), .enable_in(enable_in),
        .undervoltage_lockout_released_in(undervoltage_lockout_released_in),
        .target_voltage_code_in(target_code), .cmd_wr_in(cmd_wr_in),
        .cmd_rd_in(cmd_rd_in), .cmd_code_in(cmd_code_in),
        .cmd_wdata_in(cmd_wdata_in), .cmd_rdata_out(cmd_rdata_out),
        .limit_over_ref_in(limit_over_ref_in),
        .load_current_in(load_current_in), .phase_high_in(phase_high),
        .phase_out(phase_out), .phase_oe_out(phase_oe_out),
        .phase_sink_out(phase_sink_out), .ref_code_out(ref_code_out),
        .phase_count_out(phase_count_out), .ll_scale_out(ll_scale_out),
        .ilim_scale_out(ilim_scale_out), .ilim_trip_out(ilim_trip_out),
        .latchoff_out(latchoff_out), .startup_done_out(startup_done_out));

    mss_gate_drv_model drv (
        .clk_in(clk_in), .phase_in(phase_out), .phase_oe_in(phase_oe_out),
        .phase_sink_in(phase_sink_out), .tie_mask_in(tie_mask),
        .phase_high_out(phase_high), .pin_level_out(),
        .clash_count_out(clash_count));

    // Single verdict point for the whole run
    task automatic stop_test;
        if (err_total == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
    endtask : cyc

    task automatic cmd_write(input logic [7:0] code, input logic [7:0] data);
        @(posedge clk_in);
        cmd_wr_in    <= 1'b1;
        cmd_code_in  <= code;
        cmd_wdata_in <= data;
        @(posedge clk_in);
        cmd_wr_in <= 1'b0;
    endtask : cmd_write

    // Sampled one edge late: read data stands until the next read
    task automatic cmd_read(input logic [7:0] code, output logic [7:0] data);
        @(posedge clk_in);
        cmd_rd_in   <= 1'b1;
        cmd_code_in <= code;
        @(posedge clk_in);
        cmd_rd_in <= 1'b0;
        @(posedge clk_in);
        #1 data = cmd_rdata_out;
    endtask : cmd_read

    // Cycles the ramp dwells on one code, i.e. the step interval
    task automatic ref_gap(input logic [7:0] a, output int gap);
        int n;
        n = 0;
        gap = 0;
        while (ref_code_out !== a && n < 20000) begin
            @(posedge clk_in);
            n++;
        end
        while (ref_code_out === a && gap < 20000) begin
            @(posedge clk_in);
            gap++;
        end
    endtask : ref_gap

    // Fall-to-fall period of phase 1
    task automatic rise_gap(output int g);
        int n;
        n = 0;
        g = 0;
        while (phase_out[0] !== 1'b1 && n < 1000) begin
            @(posedge clk_in);
            n++;
        end
        while (phase_out[0] !== 1'b0 && n < 2000) begin
            @(posedge clk_in);
            n++;
        end
        while (phase_out[0] !== 1'b1 && g < 1000) begin
            @(posedge clk_in);
            g++;
        end
        while (phase_out[0] !== 1'b0 && g < 2000) begin
            @(posedge clk_in);
            g++;
        end
    endtask : rise_gap

    // Enable first, lockout release later, then check the detection outcome
    task automatic startup(input logic [5:0] ties, input logic [2:0] cnt,
                           input logic [5:0] oe_exp);
        logic bad;
        bad = 1'b0;
        @(posedge clk_in);
        tie_mask  <= ties;
        enable_in <= 1'b1;
        cyc(4);
        #1 chk("sink before start", {2'b00, phase_sink_out}, 8'h3E);
        chk("ref before release", ref_code_out, 8'h00);
        @(posedge clk_in);
        undervoltage_lockout_released_in <= 1'b1;
        repeat (220) begin
            @(posedge clk_in);
            if (phase_out[0] !== 1'b0 || ref_code_out !== 8'h00) bad = 1'b1;
        end
        chk("quiet until ramp", {7'h00, bad}, 8'h00);
        cyc(45);
        #1 chk("phase count", {5'h00, phase_count_out}, {5'h00, cnt});
        chk("not done yet", {7'h00, startup_done_out}, 8'h00);
        chk("drive enables", {2'b00, phase_oe_out}, {2'b00, oe_exp});
        chk("sinks off", {2'b00, phase_sink_out}, 8'h00);
    endtask : startup

    // Hang guard, far beyond the expected run of about ten thousand cycles
    initial begin
        cyc(40000);
        err_total++;
        stop_test();
    end

    initial begin
        logic [7:0] rd;
        int g;
        cyc(12);
        reset_in <= 1'b0;
        cyc(2);
        #1 chk("reset count", {5'h00, phase_count_out}, 8'h06);
        chk("reset limit scale", {3'h0, ilim_scale_out}, 8'h10);
        chk("reset loadline", {2'b00, ll_scale_out}, 8'h20);
        cmd_read(`MSS_CMD_SLEW, rd);
        chk("slew default", rd & 8'h07, 8'h02);
        cmd_read(`MSS_CMD_DELAY, rd);
        chk("delay default", rd & 8'h07, 8'h03);
        cmd_read(`MSS_CMD_ILIM, rd);
        chk("limit default", rd & 8'h1F, 8'h10);
        cmd_read(8'h55, rd);
        chk("unmapped read", rd, 8'h00);
        cmd_read(`MSS_CMD_IMON, rd);
        chk("load current", rd, 8'h5A);
        // Every slew and delay code, written back to back
        for (int c = 0; c < 8; c++) begin
            cmd_write(`MSS_CMD_SLEW, 8'(c));
            cmd_write(`MSS_CMD_DELAY, 8'(7 - c));
            cmd_read(`MSS_CMD_SLEW, rd);
            chk("slew code", rd & 8'h07, 8'(c));
            cmd_read(`MSS_CMD_DELAY, rd);
            chk("delay code", rd & 8'h07, 8'(7 - c));
        end
        foreach (lim_codes[i]) begin
            cmd_write(`MSS_CMD_ILIM, lim_codes[i]);
            @(posedge clk_in);
            #1 chk("limit scale", {3'h0, ilim_scale_out}, lim_codes[i]);
        end
        cmd_write(`MSS_CMD_LL_CAL, 8'h05);
        cmd_write(`MSS_CMD_LL_SET, 8'h10);
        @(posedge clk_in);
        #1 chk("loadline sum", {2'b00, ll_scale_out}, 8'h15);
        // Four phases, shortest delay, fastest slew
        startup(6'h30, 3'h4, 6'h0F);
        rise_gap(g);
        chk("phase period", 8'(g), 8'(4 * MDIV));
        ref_gap(8'h02, g);
        chk("fast step", {7'h00, g >= 830 && g <= 837}, 8'h01);
        chk("strap contention", 8'(clash_count), 8'h00);
        // Trip is checked while enabled, as a disabled part holds it clear
        @(posedge clk_in);
        limit_over_ref_in <= 1'b1;
        cyc(3);
        #1 chk("trip set", {7'h00, ilim_trip_out}, 8'h01);
        @(posedge clk_in);
        limit_over_ref_in <= 1'b0;
        cyc(3);
        #1 chk("trip clear", {7'h00, ilim_trip_out}, 8'h00);
        @(posedge clk_in);
        enable_in        <= 1'b0;
        undervoltage_lockout_released_in <= 1'b0;
        cyc(5);
        #1 chk("latchoff cleared", {7'h00, latchoff_out}, 8'h00);
        cmd_write(`MSS_CMD_SLEW, 8'h02);
        // Single phase, default slew of 2500 cycles per step
        startup(6'h3E, 3'h1, 6'h01);
        ref_gap(8'h02, g);
        chk("default step", {7'h00, g >= 2499 && g <= 2501}, 8'h01);
        chk("ramp rising", {7'h00, ref_code_out > 8'h02}, 8'h01);
        stop_test();
    end
endmodule : tb
